// >>> hbw_unit.v
// What this block does
// - Four instruction breakpoints, address and control each
// - Enabled PC comparison success raises debug interrupt
// - Control bit 1 picks equal or not-equal
// - Bits 23:16 enable per thread, reset zero
// - Bit 0 master enable, reset zero
// - Four first data-watch addresses
// - Four second data-watch addresses
// - Four data-watch control registers
// - Data-watch bit 2 enables triggering on loads
// - Data-watch bit 1 picks AND or OR
// - Four resource-watch masks
// - Four resource-watch compare values
// - Resource-watch bit 1 picks condition A or B
// - Cause code 3, 4 or 5 recorded
// - Record comparator number, thread; lowest wins
// - Capture effective address or resource identifier
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "hbw_defines.vh"

module hbw_unit #(
    parameter NUM_THREADS = 8,
    parameter THREAD_W = 3
) (
    input wire sys_clk_i,
    input wire rst_i,
    // Register port
    input wire [7:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [31:0] reg_rdata_o,
    // Instruction issue from the pipeline
    input wire pc_valid_i,
    input wire [31:0] pc_i,
    input wire [THREAD_W-1:0] pc_thread_i,
    // Memory operations from the pipeline
    input wire mem_valid_i,
    input wire mem_load_i,
    input wire [31:0] mem_addr_i,
    input wire [THREAD_W-1:0] mem_thread_i,
    // Resource operations from the pipeline
    input wire res_valid_i,
    input wire [31:0] res_id_i,
    input wire [THREAD_W-1:0] res_thread_i,
    // Debug interrupt toward the core
    output reg dbg_int_o,
    output reg [THREAD_W-1:0] dbg_int_thread_o,
    output wire irq_o
);

    // Lowest set bit of a four-bit hit vector
    function [1:0] low_index;
        input [3:0] hits;
        begin
            if (hits[0]) begin
                low_index = 2'h0;
            end else if (hits[1]) begin
                low_index = 2'h1;
            end else if (hits[2]) begin
                low_index = 2'h2;
            end else begin
                low_index = 2'h3;
            end
        end
    endfunction

    // Comparator may fire for this thread
    function armed;
        input [31:0] ctrl;
        input [THREAD_W-1:0] thr;
        reg [7:0] thr_en;
        begin
            thr_en = ctrl[`HBW_CTRL_THR_HI:`HBW_CTRL_THR_LO];
            armed = ctrl[`HBW_CTRL_ENABLE] & thr_en[thr];
        end
    endfunction

    reg [31:0] ibrk_addr [0:3];
    reg [31:0] ibrk_ctrl [0:3];
    reg [31:0] dw_addr1 [0:3];
    reg [31:0] dw_addr2 [0:3];
    reg [31:0] dw_ctrl [0:3];
    reg [31:0] rw_mask [0:3];
    reg [31:0] rw_value [0:3];
    reg [31:0] rw_ctrl [0:3];
    reg [31:0] cause;
    reg [31:0] capture;
    reg [2:0] irq_status;
    reg [2:0] irq_mask;

    reg [3:0] ibrk_hit;
    reg [3:0] dw_hit;
    reg [3:0] rw_hit;
    reg cond_a;
    reg cond_b;
    // Separate loop indices so the two processes never share a variable
    integer i;
    integer j;

    wire [1:0] sel = reg_addr_i[1:0];
    wire [5:0] set_base = reg_addr_i[7:2];

    // Comparator evaluation against the pipeline inputs
    always @* begin
        ibrk_hit = 4'h0;
        dw_hit = 4'h0;
        rw_hit = 4'h0;
        cond_a = 1'b0;
        cond_b = 1'b0;
        for (i = 0; i < 4; i = i + 1) begin
            // Equal or not-equal on the PC
            if (pc_valid_i && armed(ibrk_ctrl[i], pc_thread_i)) begin
                ibrk_hit[i] = (pc_i == ibrk_addr[i]) ^ ibrk_ctrl[i][`HBW_CTRL_COND];
            end
            cond_a = (mem_addr_i == dw_addr1[i]);
            cond_b = (mem_addr_i == dw_addr2[i]);
            // Loads qualify only when enabled; stores always
            if (mem_valid_i && armed(dw_ctrl[i], mem_thread_i)
                && (!mem_load_i || dw_ctrl[i][`HBW_CTRL_LOAD])) begin
                dw_hit[i] = dw_ctrl[i][`HBW_CTRL_COND] ? (cond_a | cond_b) : (cond_a & cond_b);
            end
            // Condition B taken as the mismatch of the masked compare
            if (res_valid_i && armed(rw_ctrl[i], res_thread_i)) begin
                rw_hit[i] = ((res_id_i & rw_mask[i]) == rw_value[i]) ^ rw_ctrl[i][`HBW_CTRL_COND];
            end
        end
    end

    wire any_ibrk = |ibrk_hit;
    wire any_dw = |dw_hit;
    wire any_rw = |rw_hit;
    wire any_hit = any_ibrk | any_dw | any_rw;
    wire [2:0] hit_events = {any_rw, any_dw, any_ibrk};

    // Register writes and hit recording
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            for (j = 0; j < 4; j = j + 1) begin
                ibrk_addr[j] <= 32'h00000000;
                ibrk_ctrl[j] <= `HBW_CTRL_RESET;
                dw_addr1[j] <= 32'h00000000;
                dw_addr2[j] <= 32'h00000000;
                dw_ctrl[j] <= `HBW_CTRL_RESET;
                rw_mask[j] <= 32'h00000000;
                rw_value[j] <= 32'h00000000;
                rw_ctrl[j] <= `HBW_CTRL_RESET;
            end
            cause <= 32'h00000000;
            capture <= 32'h00000000;
            irq_mask <= 3'h0;
        end else begin
            if (reg_wr_i) begin
                case (set_base)
                    6'h0c: ibrk_addr[sel] <= reg_wdata_i;
                    6'h10: ibrk_ctrl[sel] <= reg_wdata_i & `HBW_IBRK_CTRL_WMASK;
                    6'h14: dw_addr1[sel] <= reg_wdata_i;
                    6'h18: dw_addr2[sel] <= reg_wdata_i;
                    6'h1c: dw_ctrl[sel] <= reg_wdata_i & `HBW_DW_CTRL_WMASK;
                    6'h20: rw_mask[sel] <= reg_wdata_i;
                    6'h24: rw_value[sel] <= reg_wdata_i;
                    6'h27: rw_ctrl[sel] <= reg_wdata_i & `HBW_RW_CTRL_WMASK;
                    default: ;
                endcase
                if (reg_addr_i == `HBW_CAUSE_REG) begin
                    cause <= reg_wdata_i & `HBW_CAUSE_WMASK;
                end
                if (reg_addr_i == `HBW_DATA_REG) begin
                    capture <= reg_wdata_i;
                end
                if (reg_addr_i == `HBW_IRQ_MASK_REG) begin
                    irq_mask <= reg_wdata_i[2:0];
                end
            end
            // A hit overrides a software write to cause, and a data or resource hit one to capture, in the same cycle
            if (any_ibrk) begin
                cause <= {14'h0000, low_index(ibrk_hit), 5'h00, pc_thread_i, 5'h00, `HBW_CAUSE_IBRK};
            end else if (any_dw) begin
                cause <= {14'h0000, low_index(dw_hit), 5'h00, mem_thread_i, 5'h00, `HBW_CAUSE_DWATCH};
                capture <= mem_addr_i;
            end else if (any_rw) begin
                cause <= {14'h0000, low_index(rw_hit), 5'h00, res_thread_i, 5'h00, `HBW_CAUSE_RWATCH};
                capture <= res_id_i;
            end
        end
    end

    // Debug interrupt pulse and thread toward the core
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            dbg_int_o <= 1'b0;
            dbg_int_thread_o <= {THREAD_W{1'b0}};
        end else begin
            dbg_int_o <= any_hit;
            if (any_ibrk) begin
                dbg_int_thread_o <= pc_thread_i;
            end else if (any_dw) begin
                dbg_int_thread_o <= mem_thread_i;
            end else if (any_rw) begin
                dbg_int_thread_o <= res_thread_i;
            end
        end
    end

    // Sticky status, write one to clear, new event wins
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            irq_status <= 3'h0;
        end else if (reg_wr_i && reg_addr_i == `HBW_IRQ_STATUS_REG) begin
            irq_status <= (irq_status & ~reg_wdata_i[2:0]) | hit_events;
        end else begin
            irq_status <= irq_status | hit_events;
        end
    end

    assign irq_o = |(irq_status & irq_mask);

    // Read data, one cycle after the strobe
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (reg_rd_i) begin
            case (set_base)
                6'h0c: reg_rdata_o <= ibrk_addr[sel];
                6'h10: reg_rdata_o <= ibrk_ctrl[sel];
                6'h14: reg_rdata_o <= dw_addr1[sel];
                6'h18: reg_rdata_o <= dw_addr2[sel];
                6'h1c: reg_rdata_o <= dw_ctrl[sel];
                6'h20: reg_rdata_o <= rw_mask[sel];
                6'h24: reg_rdata_o <= rw_value[sel];
                6'h27: reg_rdata_o <= rw_ctrl[sel];
                default: begin
                    if (reg_addr_i == `HBW_CAUSE_REG) begin
                        reg_rdata_o <= cause;
                    end else if (reg_addr_i == `HBW_DATA_REG) begin
                        reg_rdata_o <= capture;
                    end else if (reg_addr_i == `HBW_IRQ_STATUS_REG) begin
                        reg_rdata_o <= {29'h00000000, irq_status};
                    end else if (reg_addr_i == `HBW_IRQ_MASK_REG) begin
                        reg_rdata_o <= {29'h00000000, irq_mask};
                    end else begin
                        reg_rdata_o <= 32'h00000000;
                    end
                end
            endcase
        end else begin
            reg_rdata_o <= 32'h00000000;
        end
    end

endmodule // hbw_unit

`default_nettype wire

// >>> hbw_defines.vh
`ifndef HBW_DEFINES_VH
`define HBW_DEFINES_VH

// Register numbers, base of each set of four, then the single registers
`define HBW_IBRK_ADDR_BASE 8'h30
`define HBW_IBRK_CTRL_BASE 8'h40
`define HBW_DW_ADDR1_BASE 8'h50
`define HBW_DW_ADDR2_BASE 8'h60
`define HBW_DW_CTRL_BASE 8'h70
`define HBW_RW_MASK_BASE 8'h80
`define HBW_RW_VALUE_BASE 8'h90
`define HBW_RW_CTRL_BASE 8'h9c
`define HBW_CAUSE_REG 8'h15
`define HBW_DATA_REG 8'h16
`define HBW_IRQ_STATUS_REG 8'ha0
`define HBW_IRQ_MASK_REG 8'ha1

// Control register fields
`define HBW_CTRL_ENABLE 0
`define HBW_CTRL_COND 1
`define HBW_CTRL_LOAD 2
`define HBW_CTRL_THR_LO 16
`define HBW_CTRL_THR_HI 23

// Writable bits of each control kind and of cause, then the control reset value
`define HBW_IBRK_CTRL_WMASK 32'h00ff0003
`define HBW_DW_CTRL_WMASK 32'h00ff0007
`define HBW_RW_CTRL_WMASK 32'h00ff0003
`define HBW_CAUSE_WMASK 32'h0003ff07
`define HBW_CTRL_RESET 32'h00000000

// Cause codes
`define HBW_CAUSE_IBRK 3'h3
`define HBW_CAUSE_DWATCH 3'h4
`define HBW_CAUSE_RWATCH 3'h5

// Interrupt status bits
`define HBW_IRQ_IBRK 0
`define HBW_IRQ_DW 1
`define HBW_IRQ_RW 2

`endif

// >>> hbw_unit_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module hbw_unit_assertions #(parameter THREAD_W = 3) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic pc_valid_i,
    input wire logic [THREAD_W-1:0] pc_thread_i,
    input wire logic mem_valid_i,
    input wire logic res_valid_i,
    input wire logic dbg_int_o,
    input wire logic [THREAD_W-1:0] dbg_int_thread_o,
    input wire logic irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // Pipeline activity shapes
    sequence s_quiet;
        !pc_valid_i && !mem_valid_i && !res_valid_i;
    endsequence
    sequence s_pc_hit;
        pc_valid_i && !mem_valid_i && !res_valid_i ##1 dbg_int_o;
    endsequence
    // Register port
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data not idle");
    a_ibrk_reserved: assert property (reg_rd_i && reg_addr_i[7:2] == 6'h10 |=>
        reg_rdata_o[31:24] == 8'h0 && reg_rdata_o[15:2] == 14'h0) else $error("ibrk reserved bits");
    a_dw_reserved: assert property (reg_rd_i && reg_addr_i[7:2] == 6'h1c |=>
        reg_rdata_o[31:24] == 8'h0 && reg_rdata_o[15:3] == 13'h0) else $error("dw reserved bits");
    a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 8'h17 |=> reg_rdata_o == 32'h0)
        else $error("unmapped read");
    // Debug interrupt
    a_quiet_no_hit: assert property (s_quiet |=> !dbg_int_o)
        else $error("hit without issue");
    a_irq_cause: assert property ($rose(irq_o) |-> dbg_int_o || $past(reg_wr_i))
        else $error("irq without cause");
    a_thread_hold: assert property (!dbg_int_o && !$past(rst_i) |-> $stable(dbg_int_thread_o))
        else $error("thread moved");
    a_thread_pc: assert property (s_pc_hit |-> dbg_int_thread_o == $past(pc_thread_i))
        else $error("thread not from pc");
endmodule // hbw_unit_assertions
bind hbw_unit hbw_unit_assertions #(.THREAD_W(THREAD_W)) u_chk (.sys_clk_i, .rst_i, .reg_addr_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pc_valid_i, .pc_thread_i, .mem_valid_i, .res_valid_i,
    .dbg_int_o, .dbg_int_thread_o, .irq_o);
`default_nettype wire

// >>> hbw_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
module hbw_pipe_model (
    input wire logic clk_i,
    output logic pc_valid_o,
    output logic [31:0] pc_o,
    output logic [2:0] pc_thread_o,
    output logic mem_valid_o,
    output logic mem_load_o,
    output logic [31:0] mem_addr_o,
    output logic [2:0] mem_thread_o,
    output logic res_valid_o,
    output logic [31:0] res_id_o,
    output logic [2:0] res_thread_o
);
    // Idle pipeline from time zero
    initial {pc_valid_o, mem_valid_o, res_valid_o, mem_load_o} = 4'h0;
    initial {pc_o, mem_addr_o, res_id_o, pc_thread_o, mem_thread_o, res_thread_o} = 105'h0;
    // One issue cycle; k picks pc, memory and resource sources
    task automatic issue(input logic [2:0] k, input logic [31:0] v, input logic [2:0] t, input logic ld);
        @(posedge clk_i);
        {res_valid_o, mem_valid_o, pc_valid_o} <= k;
        {pc_o, mem_addr_o, res_id_o, pc_thread_o, mem_thread_o, res_thread_o} <= {v, v, v, t, t, t};
        mem_load_o <= ld;
        @(posedge clk_i);
        {res_valid_o, mem_valid_o, pc_valid_o} <= 3'h0;
        // Released lines flip so a stale value never matches
        {pc_o, mem_addr_o, res_id_o, mem_load_o} <= {~v, ~v, ~v, ~ld};
        #1;
    endtask
endmodule // hbw_pipe_model
`default_nettype wire

// >>> tb_hbw_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_hbw_unit;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    wire [31:0] reg_rdata_o, pc_i, mem_addr_i, res_id_i;
    wire pc_valid_i, mem_valid_i, mem_load_i, res_valid_i, dbg_int_o, irq_o;
    wire [2:0] pc_thread_i, mem_thread_i, res_thread_i, dbg_int_thread_o;
    logic [31:0] m [0:255];
    logic [7:0] base [10] = '{8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'h90, 8'h9c, 8'h14, 8'ha0};
    logic [31:0] seed = 32'h52b7;
    logic [2:0] exp_thr = 3'h0;
    int n_mismatch = 0;
    int n_compared = 0;
    hbw_unit dut_u (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .pc_valid_i, .pc_i, .pc_thread_i, .mem_valid_i, .mem_load_i, .mem_addr_i, .mem_thread_i,
        .res_valid_i, .res_id_i, .res_thread_i, .dbg_int_o, .dbg_int_thread_o, .irq_o);
    hbw_pipe_model pm_u (.clk_i(sys_clk_i), .pc_valid_o(pc_valid_i), .pc_o(pc_i), .pc_thread_o(pc_thread_i),
        .mem_valid_o(mem_valid_i), .mem_load_o(mem_load_i), .mem_addr_o(mem_addr_i),
        .mem_thread_o(mem_thread_i), .res_valid_o(res_valid_i), .res_id_o(res_id_i), .res_thread_o(res_thread_i));
    initial forever #4 sys_clk_i = ~sys_clk_i;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Writable bits of each register number
    function automatic logic [31:0] wmask(logic [7:0] a);
        case (a[7:2])
            6'h0c, 6'h14, 6'h18, 6'h20, 6'h24: return 32'hffffffff;
            6'h10, 6'h27: return 32'h00ff0003;
            6'h1c: return 32'h00ff0007;
            default: return a == 8'h15 ? 32'h0003ff07 : a == 8'h16 ? 32'hffffffff : a == 8'ha1 ? 32'h7 : 32'h0;
        endcase
    endfunction
    // Whether comparator i of kind kd fires on one issue
    function automatic logic fires(int kd, int i, logic [31:0] v, int t, logic ld);
        logic [31:0] c;
        logic a;
        logic b;
        c = m[kd == 0 ? 8'h40 + i : kd == 1 ? 8'h70 + i : 8'h9c + i];
        a = v == m[8'h50 + i];
        b = v == m[8'h60 + i];
        if (!c[0] || !c[16 + t]) return 1'b0;
        if (kd == 0) return (v == m[8'h30 + i]) ^ c[1];
        if (kd == 1) return (!ld || c[2]) && (c[1] ? a | b : a & b);
        return ((v & m[8'h80 + i]) == m[8'h90 + i]) ^ c[1];
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        m[a] = a == 8'ha0 ? m[a] & ~d : d & wmask(a);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk_i);
        {reg_rd_i, reg_addr_i} <= {1'b1, a};
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 check(reg_rdata_o, m[a]);
    endtask
    // Issue, then predict hit, thread, cause, capture and status
    task automatic pipe(input logic [2:0] k, input logic [31:0] v, input logic [2:0] t, input logic ld);
        int wk;
        wk = -1;
        pm_u.issue(k, v, t, ld);
        for (int kd = 2; kd >= 0; kd--) begin
            for (int i = 3; i >= 0; i--) begin
                if (k[kd] && fires(kd, i, v, t, ld)) begin
                    wk = kd;
                    m[8'ha0][kd] = 1'b1;
                    m[8'h15] = (i << 16) | (t << 8) | (3 + kd);
                end
            end
        end
        if (wk > 0) m[8'h16] = v;
        if (wk >= 0) exp_thr = t;
        check(dbg_int_o, wk >= 0);
        check(dbg_int_thread_o, exp_thr);
        check(irq_o, |(m[8'ha0] & m[8'ha1]));
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #500000;
        n_mismatch++;
        summarize();
    end
    initial begin
        for (int a = 0; a < 256; a++) m[a] = 32'h0;
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        foreach (base[b]) for (int i = 0; i < 4; i++) rd(base[b] + i);
        $display("reset values done");
        foreach (base[b]) for (int i = 0; i < 4; i++) wr(base[b] + i, rnd());
        foreach (base[b]) for (int i = 0; i < 4; i++) rd(base[b] + i);
        $display("register access done");
        for (int n = 0; n < 160; n++) begin
            if (n % 16 == 0) for (int b = 0; b < 8; b++) for (int i = 0; i < 4; i++) wr(base[b] + i,
                b % 3 == 1 ? rnd() : rnd() & 32'h3);
            if (n % 16 == 0) wr(8'ha1, rnd());
            pipe(rnd(), rnd() & 32'h3, rnd(), rnd());
            rd(8'h15);
            rd(8'h16);
            rd(8'ha0);
            wr(8'ha0, rnd());
        end
        $display("comparator traffic done");
        summarize();
    end
endmodule // tb_hbw_unit
`default_nettype wire
